// ### core/irwc_pkg.sv
package irwc_pkg;
    // ****************************************
    // Register addresses on the core port
    // ****************************************
    localparam logic [5:0] IRWC_ADDR_TIMER   = 6'h01;
    localparam logic [5:0] IRWC_ADDR_STATUS  = 6'h03;
    localparam logic [5:0] IRWC_ADDR_BANK    = 6'h04;
    localparam logic [5:0] IRWC_ADDR_MODE    = 6'h0A;
    localparam logic [5:0] IRWC_ADDR_DAC     = 6'h0B;
    localparam logic [5:0] IRWC_ADDR_RAMADR  = 6'h0C;
    localparam logic [5:0] IRWC_ADDR_ADCTL   = 6'h0E;
    localparam logic [5:0] IRWC_ADDR_FLAG    = 6'h0F;
    localparam logic [5:0] IRWC_ADDR_MASK    = 6'h2F;
    localparam logic [5:0] IRWC_ADDR_CONFIG  = 6'h3F;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int IRWC_BIT_PAB      = 3;
    localparam int IRWC_BIT_GIE      = 6;
    localparam int IRWC_BIT_IDLE_SEL = 7;
    localparam int IRWC_BIT_NORMAL   = 6;
    localparam int IRWC_BIT_WD_EN    = 5;
    localparam int IRWC_FLAG_TIMER   = 0;
    localparam int IRWC_FLAG_COUNTER_ONE_FLAG    = 1;
    localparam int IRWC_FLAG_COUNTER_TWO_FLAG    = 2;
    localparam int IRWC_FLAG_EXT_LO  = 3;
    localparam int IRWC_FLAG_EXT_HI  = 4;
    localparam int IRWC_FLAG_ADC     = 5;
    // ****************************************
    // Reset values and vectors
    // ****************************************
    localparam logic [7:0]  IRWC_RST_ZERO   = 8'h00;
    localparam logic [7:0]  IRWC_RST_ONES   = 8'hFF;
    localparam logic [7:0]  IRWC_IRQ_MASK6  = 8'h3F;
    localparam logic [12:0] IRWC_VEC_RESET  = 13'h0000;
    localparam logic [12:0] IRWC_VEC_SOFT   = 13'h0001;
    localparam logic [12:0] IRWC_VEC_HW     = 13'h0008;
    localparam int          IRWC_WD_BITS    = 8;

    typedef enum logic [1:0] {
        IRWC_RUN,
        IRWC_SLEEP,
        IRWC_IDLE
    } irwc_pwr_t;

    typedef struct packed {
        logic       wr;
        logic [5:0] addr;
        logic [7:0] data;
    } irwc_wr_t;

    typedef struct packed {
        logic wd_clear;
        logic power_down;
        logic irq_on;
        logic irq_off;
        logic ret_irq;
        logic soft_irq;
    } irwc_instr_t;
endpackage

// ### core/irwc_ctrl.sv
`timescale 1ns/1ns
// Contract
// - Mask bits 0-5 enable one source each; bits 6-7 read zero.
// - One 8-bit prescaler serves timer or watchdog, chosen by bit 3.
// - Writing the main timer clears timer count and prescaler.
// - Watchdog-owned prescaler cleared by watchdog-clear or power-down.
// - Timer-owned prescaler unchanged by power-down instruction.
// - First reset source is power-on or voltage detector by option.
// - Watchdog timeout resets only if enabled, in green, normal or sleep.
// - Any reset clears program counter, fetch from 000H.
// - Power-on clears status upper three and bank upper two bits.
// - Reset clears watchdog count and prescaler, watchdog disabled.
// - Reset loads all ones into core configuration register.
// - Reset values of DAC, RAM address, converter, flag, mask fixed.
// - Idle wakes on timer or watchdog; sleep watchdog timeout resets, except with bit 3 set and bits 2-0 nonzero (prescaler held in sleep).
// - Idle timer wake sets flag bit 0 and vectors to 0x08 if enabled.
// - Green or normal timer timeout sets flag, vectors if enabled.
// - Falling edge of an enabled source sets its flag bit.
// - Global enable and disable instructions, independent of mask.
// - Enabled interrupt with global enable fetches from 008H.
// - Instruction-raised interrupts vector to 001H.
// - Port 7 bits 0-3 raise flag bit 3 when mask bit 3 set.
// - Port 7 bits 4-7 raise flag bit 4 when mask bit 4 set.
// - Mode bit 7 picks sleep or idle; bit 6 normal or green.
// - Flag layout bits 0-5 sources; bits 6-7 read zero.
// - Software reads flags and clears them by writing.
module irwc_ctrl
    import irwc_pkg::*;
#(
    parameter int PRESCALE_BITS = 8
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        clk_en_in,
    input  wire logic        por_in,
    input  wire logic        volt_det_rst_in,
    input  wire logic        volt_det_sel_in,
    input  wire irwc_wr_t    reg_wr_in,
    input  wire logic [5:0]  reg_rd_addr_in,
    input  wire irwc_instr_t instr_in,
    input  wire logic        timer_clk_in,
    input  wire logic        wd_clk_in,
    input  wire logic        counter_one_flag_ovf_n_in,
    input  wire logic        counter_two_flag_ovf_n_in,
    input  wire logic        adc_done_n_in,
    input  wire logic [7:0]  port7_in,
    output logic [7:0]       reg_rd_data_out,
    output logic [7:0]       port7_data_out,
    output logic             irq_req_out,
    output logic             vec_load_out,
    output logic [12:0]      vec_addr_out,
    output logic             cpu_halt_out,
    output logic             sys_reset_out,
    output logic [7:0]       timer_out
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]               mask_r;
    logic [7:0]               flag_r;
    logic [7:0]               config_r;
    logic [7:0]               timer_r;
    logic [PRESCALE_BITS-1:0] pre_r;
    logic [IRWC_WD_BITS-1:0]  wd_r;
    logic [7:0]               mode_r;
    logic [7:0]               status_r;
    logic [7:0]               bank_r;
    logic [7:0]               dac_r;
    logic [7:0]               ramadr_r;
    logic [7:0]               adctl_r;
    logic [7:0]               port7_r;
    logic [2:0]               src_r;
    irwc_pwr_t                pwr_r;
    logic                     wd_rst_r;

    logic        pre_wd;
    logic        pre_tick;
    logic        timer_step;
    logic        timer_ovf;
    logic        wd_step;
    logic        wd_ovf;
    logic        wd_en;
    logic        any_rst;
    logic        cold_rst;
    logic [7:0]  flag_set;
    logic [7:0]  flag_nxt;
    logic        timer_wr;
    logic        fall7_lo;
    logic        fall7_hi;
    logic [2:0]  src_fall;
    logic        pending;
    logic        hw_take;

    function automatic logic is_wr(input irwc_wr_t w,
                                   input logic [5:0] a);
        return w.wr && (w.addr == a);
    endfunction

    // Rate select: ratio of 2^(psr+1) for timer, 2^psr for watchdog
    function automatic logic pre_done(input logic [PRESCALE_BITS-1:0] p,
                                      input logic [2:0] psr,
                                      input logic to_wd);
        logic [3:0] n;
        logic [PRESCALE_BITS-1:0] m;
        n = {1'b0, psr} + {3'b000, ~to_wd};
        m = PRESCALE_BITS'((9'h001 << n) - 9'h001);
        return (p & m) == m;
    endfunction

    // ****************************************
    // Reset sources
    // ****************************************
    assign cold_rst = ~rst_n_in
                    | (volt_det_sel_in ? volt_det_rst_in : por_in);
    assign any_rst  = cold_rst | wd_rst_r;
    assign sys_reset_out = any_rst;
    assign wd_en    = mode_r[IRWC_BIT_WD_EN];

    // ****************************************
    // Shared prescaler and timers
    // ****************************************
    assign pre_wd   = config_r[IRWC_BIT_PAB];
    assign timer_wr = is_wr(reg_wr_in, IRWC_ADDR_TIMER);
    assign pre_tick = pre_done(pre_r, config_r[2:0], pre_wd);
    assign timer_step = pre_wd ? timer_clk_in
                               : (timer_clk_in && pre_tick);
    assign wd_step  = pre_wd ? (wd_clk_in && pre_tick) : wd_clk_in;
    assign timer_ovf = timer_step && (timer_r == IRWC_RST_ONES);
    assign wd_ovf   = wd_en && wd_step && (&wd_r);

    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            pre_r <= '0;
        end else if (clk_en_in) begin
            if (timer_wr) begin
                pre_r <= '0;
            end else if (pre_wd && (instr_in.wd_clear
                                    || instr_in.power_down)) begin
                pre_r <= '0;
            end else if ((pre_wd ? wd_clk_in : timer_clk_in)
                         && pwr_r != IRWC_SLEEP) begin
                // Power-down alone never touches a timer-owned count
                pre_r <= pre_tick ? '0 : pre_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            timer_r <= IRWC_RST_ZERO;
        end else if (clk_en_in) begin
            if (timer_wr) begin
                timer_r <= IRWC_RST_ZERO;
            end else if (timer_step && pwr_r != IRWC_SLEEP) begin
                timer_r <= timer_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            wd_r <= '0;
        end else if (clk_en_in) begin
            if (instr_in.wd_clear || instr_in.power_down || !wd_en) begin
                wd_r <= '0;
            end else if (wd_step) begin
                wd_r <= wd_r + 1'b1;
            end
        end
    end

    // Sleep or run: timeout resets; idle: it only wakes
    always_ff @(posedge clk_sys_in) begin
        if (cold_rst || wd_rst_r) begin
            wd_rst_r <= 1'b0;
        end else if (clk_en_in) begin
            wd_rst_r <= wd_ovf && (pwr_r != IRWC_IDLE);
        end
    end

    // ****************************************
    // Power mode
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            pwr_r <= IRWC_RUN;
        end else if (clk_en_in) begin
            unique case (pwr_r)
                IRWC_RUN: begin
                    if (instr_in.power_down) begin
                        pwr_r <= mode_r[IRWC_BIT_IDLE_SEL] ? IRWC_IDLE
                                                           : IRWC_SLEEP;
                    end
                end
                IRWC_IDLE: begin
                    if (timer_ovf || wd_ovf) begin
                        pwr_r <= IRWC_RUN;
                    end
                end
                IRWC_SLEEP: begin
                    pwr_r <= IRWC_SLEEP;
                end
                default: begin
                    pwr_r <= IRWC_RUN;
                end
            endcase
        end
    end
    assign cpu_halt_out = (pwr_r != IRWC_RUN);

    // ****************************************
    // Interrupt flags
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            src_r   <= 3'b000;
            port7_r <= IRWC_RST_ZERO;
        end else if (clk_en_in) begin
            src_r   <= {adc_done_n_in, counter_two_flag_ovf_n_in, counter_one_flag_ovf_n_in};
            port7_r <= port7_in;
        end
    end

    assign src_fall = src_r & ~{adc_done_n_in, counter_two_flag_ovf_n_in,
                                counter_one_flag_ovf_n_in};
    assign fall7_lo = |(port7_r[3:0] & ~port7_in[3:0]);
    assign fall7_hi = |(port7_r[7:4] & ~port7_in[7:4]);

    always_comb begin
        flag_set = IRWC_RST_ZERO;
        flag_set[IRWC_FLAG_TIMER]  = timer_ovf;
        flag_set[IRWC_FLAG_COUNTER_ONE_FLAG]   = src_fall[0] && mask_r[IRWC_FLAG_COUNTER_ONE_FLAG];
        flag_set[IRWC_FLAG_COUNTER_TWO_FLAG]   = src_fall[1] && mask_r[IRWC_FLAG_COUNTER_TWO_FLAG];
        flag_set[IRWC_FLAG_EXT_LO] = fall7_lo
                                   && mask_r[IRWC_FLAG_EXT_LO];
        flag_set[IRWC_FLAG_EXT_HI] = fall7_hi
                                   && mask_r[IRWC_FLAG_EXT_HI];
        flag_set[IRWC_FLAG_ADC]    = src_fall[2] && mask_r[IRWC_FLAG_ADC];
        flag_nxt = flag_r;
        if (is_wr(reg_wr_in, IRWC_ADDR_FLAG)) begin
            flag_nxt = flag_r & reg_wr_in.data;
        end
        // A new event outranks a same-cycle software clear
        flag_nxt = (flag_nxt | flag_set) & IRWC_IRQ_MASK6;
    end

    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            flag_r <= IRWC_RST_ZERO;
        end else if (clk_en_in) begin
            flag_r <= flag_nxt;
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            mask_r   <= IRWC_RST_ZERO;
            dac_r    <= IRWC_RST_ONES;
            ramadr_r <= IRWC_RST_ZERO;
            adctl_r  <= IRWC_RST_ZERO;
            mode_r   <= IRWC_RST_ZERO;
        end else if (clk_en_in && reg_wr_in.wr) begin
            unique case (reg_wr_in.addr)
                IRWC_ADDR_MASK:   mask_r <= reg_wr_in.data
                                          & IRWC_IRQ_MASK6;
                IRWC_ADDR_DAC:    dac_r    <= reg_wr_in.data;
                IRWC_ADDR_RAMADR: ramadr_r <= reg_wr_in.data;
                IRWC_ADDR_ADCTL:  adctl_r  <= reg_wr_in.data;
                IRWC_ADDR_MODE:   mode_r   <= reg_wr_in.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (cold_rst) begin
            status_r <= IRWC_RST_ZERO;
            bank_r   <= IRWC_RST_ZERO;
        end else if (clk_en_in) begin
            if (is_wr(reg_wr_in, IRWC_ADDR_STATUS)) begin
                status_r <= reg_wr_in.data;
            end
            if (is_wr(reg_wr_in, IRWC_ADDR_BANK)) begin
                bank_r <= reg_wr_in.data;
            end
        end
    end

    // Global enable lives in bit 6 of the core config word
    // Dropped on the edge the hardware vector is taken: no double entry
    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            config_r <= IRWC_RST_ONES;
        end else if (clk_en_in) begin
            if (hw_take || instr_in.irq_off) begin
                config_r[IRWC_BIT_GIE] <= 1'b0;
            end else if (instr_in.irq_on || instr_in.ret_irq) begin
                config_r[IRWC_BIT_GIE] <= 1'b1;
            end else if (is_wr(reg_wr_in, IRWC_ADDR_CONFIG)) begin
                config_r <= reg_wr_in.data;
            end
        end
    end

    // ****************************************
    // Request and vectoring
    // ****************************************
    assign pending = |(flag_r & mask_r & IRWC_IRQ_MASK6);
    assign irq_req_out = pending && config_r[IRWC_BIT_GIE];
    assign hw_take     = irq_req_out && !vec_load_out
                      && pwr_r == IRWC_RUN && !instr_in.soft_irq;

    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            vec_load_out <= 1'b1;
            vec_addr_out <= IRWC_VEC_RESET;
        end else if (clk_en_in) begin
            vec_load_out <= 1'b0;
            if (instr_in.soft_irq) begin
                vec_load_out <= 1'b1;
                vec_addr_out <= IRWC_VEC_SOFT;
            end else if (hw_take) begin
                vec_load_out <= 1'b1;
                vec_addr_out <= IRWC_VEC_HW;
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge clk_sys_in) begin
        if (any_rst) begin
            reg_rd_data_out <= IRWC_RST_ZERO;
            port7_data_out  <= IRWC_RST_ZERO;
            timer_out       <= IRWC_RST_ZERO;
        end else if (clk_en_in) begin
            port7_data_out <= port7_in;
            timer_out      <= timer_r;
            unique case (reg_rd_addr_in)
                IRWC_ADDR_TIMER:  reg_rd_data_out <= timer_r;
                IRWC_ADDR_STATUS: reg_rd_data_out <= status_r;
                IRWC_ADDR_BANK:   reg_rd_data_out <= bank_r;
                IRWC_ADDR_MODE:   reg_rd_data_out <= mode_r;
                IRWC_ADDR_DAC:    reg_rd_data_out <= dac_r;
                IRWC_ADDR_RAMADR: reg_rd_data_out <= ramadr_r;
                IRWC_ADDR_ADCTL:  reg_rd_data_out <= adctl_r;
                IRWC_ADDR_FLAG:   reg_rd_data_out <= flag_r;
                IRWC_ADDR_MASK:   reg_rd_data_out <= mask_r;
                IRWC_ADDR_CONFIG: reg_rd_data_out <= config_r;
                default:          reg_rd_data_out <= IRWC_RST_ZERO;
            endcase
        end
    end
endmodule // irwc_ctrl

// ### tb/irwc_ctrl_monitor.sv
`timescale 1ns/1ns
module irwc_ctrl_monitor
    import irwc_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    input wire logic        clk_en_in,
    input wire logic        por_in,
    input wire logic        volt_det_rst_in,
    input wire logic        volt_det_sel_in,
    input wire irwc_wr_t    reg_wr_in,
    input wire logic [5:0]  reg_rd_addr_in,
    input wire irwc_instr_t instr_in,
    input wire logic [7:0]  reg_rd_data_out,
    input wire logic        irq_req_out,
    input wire logic        vec_load_out,
    input wire logic [12:0] vec_addr_out,
    input wire logic        cpu_halt_out,
    input wire logic        sys_reset_out,
    input wire logic [7:0]  timer_out
);
    // ****************************************
    // Port checks
    // ****************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic go;
    // Enabled edge with no reset source pending
    assign go = clk_en_in && !sys_reset_out;
    a_gie_off: assert property (go && instr_in.irq_off && !instr_in.irq_on
        && !instr_in.ret_irq && !reg_wr_in.wr |=> !irq_req_out)
        else $error("request after global disable");
    a_hw_vector: assert property (go && irq_req_out && !vec_load_out
        && !cpu_halt_out && !instr_in.soft_irq && !instr_in.irq_off
        |=> vec_load_out && vec_addr_out == IRWC_VEC_HW && !irq_req_out)
        else $error("hardware vector missing");
    a_soft_vector: assert property (go && instr_in.soft_irq
        && !irq_req_out && !vec_load_out
        |=> vec_load_out && vec_addr_out == IRWC_VEC_SOFT)
        else $error("soft vector missing");
    a_reset_source: assert property (
        (volt_det_sel_in ? volt_det_rst_in : por_in) |-> sys_reset_out)
        else $error("selected reset source ignored");
    a_reset_vector: assert property (sys_reset_out && clk_en_in
        |=> vec_load_out && vec_addr_out == IRWC_VEC_RESET
        && timer_out == IRWC_RST_ZERO && !cpu_halt_out)
        else $error("reset vector or timer wrong");
    a_halt_entry: assert property (go && instr_in.power_down
        && !irq_req_out |=> cpu_halt_out)
        else $error("power down not taken");
    // Copy on timer_out lags the count by one enabled edge
    a_timer_clear: assert property (go && reg_wr_in.wr
        && reg_wr_in.addr == IRWC_ADDR_TIMER ##1 clk_en_in
        |=> timer_out == IRWC_RST_ZERO)
        else $error("timer not cleared on write");
    a_rd_zero_bits: assert property (go && (reg_rd_addr_in == IRWC_ADDR_MASK
        || reg_rd_addr_in == IRWC_ADDR_FLAG) |=> reg_rd_data_out[7:6] == 2'b00)
        else $error("upper flag or mask bits set");
endmodule // irwc_ctrl_monitor
bind irwc_ctrl irwc_ctrl_monitor i_irwc_ctrl_monitor (
    .clk_sys_in, .rst_n_in, .clk_en_in, .por_in, .volt_det_rst_in,
    .volt_det_sel_in, .reg_wr_in, .reg_rd_addr_in, .instr_in,
    .reg_rd_data_out, .irq_req_out, .vec_load_out, .vec_addr_out,
    .cpu_halt_out, .sys_reset_out, .timer_out
);

// ### tb/irwc_cpu_model.sv
`timescale 1ns/1ns
module irwc_cpu_model (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        clk_en_in,
    input  wire logic        vec_load_in,
    input  wire logic [12:0] vec_addr_in,
    input  wire logic        halt_in,
    output logic [12:0]      pc_out
);
    // Fetch address; vector load wins over halt
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pc_out <= 13'h0000;
        end else if (clk_en_in && vec_load_in) begin
            pc_out <= vec_addr_in;
        end else if (clk_en_in && !halt_in) begin
            pc_out <= pc_out + 13'h0001;
        end
    end
endmodule // irwc_cpu_model

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import irwc_pkg::*;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("Error %0t got %h exp %h", $time, a, e); end end
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in, clk_en_in, por_in, volt_det_rst_in;
    logic        volt_det_sel_in, timer_clk_in, wd_clk_in;
    logic        counter_one_flag_ovf_n_in, counter_two_flag_ovf_n_in, adc_done_n_in;
    irwc_wr_t    reg_wr_in;
    irwc_instr_t instr_in;
    logic [5:0]  reg_rd_addr_in;
    logic [7:0]  port7_in, reg_rd_data_out, port7_data_out, timer_out, r, rx;
    logic        irq_req_out, vec_load_out, cpu_halt_out, sys_reset_out;
    logic [12:0] vec_addr_out, pc, v;
    logic        rd_go = 1'b0, rd_seen = 1'b0, armed = 1'b0, rst_seen;
    logic [7:0]  rq[$];
    logic [12:0] vq[$];
    int          miscompares = 0, n_checks = 0, cyc = 0;
    localparam logic [5:0] RA [9] = '{IRWC_ADDR_MASK, IRWC_ADDR_FLAG,
        IRWC_ADDR_CONFIG, IRWC_ADDR_DAC, IRWC_ADDR_RAMADR, IRWC_ADDR_ADCTL,
        IRWC_ADDR_TIMER, IRWC_ADDR_STATUS, IRWC_ADDR_BANK};
    localparam logic [7:0] RV [9] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MD [2] = '{8'h80, 8'h40};
    // {select, power-on, detector, reset expected}
    localparam logic [3:0] RT [4] = '{4'h5, 4'hB, 4'hC, 4'h2};
    irwc_ctrl i_irwc_ctrl (
        .clk_sys_in, .rst_n_in, .clk_en_in, .por_in, .volt_det_rst_in,
        .volt_det_sel_in, .reg_wr_in, .reg_rd_addr_in, .instr_in,
        .timer_clk_in, .wd_clk_in, .counter_one_flag_ovf_n_in, .counter_two_flag_ovf_n_in,
        .adc_done_n_in, .port7_in, .reg_rd_data_out, .port7_data_out,
        .irq_req_out, .vec_load_out, .vec_addr_out, .cpu_halt_out,
        .sys_reset_out, .timer_out
    );
    irwc_cpu_model i_irwc_cpu_model (
        .clk_sys_in, .rst_n_in, .clk_en_in, .vec_load_in(vec_load_out),
        .vec_addr_in(vec_addr_out), .halt_in(cpu_halt_out), .pc_out(pc)
    );
    // ****************************************
    // Clock, watchdog on the run, result monitor
    // ****************************************
    always #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    // Empty queue yields x so a stray vector always mismatches
    always @(posedge clk_sys_in) begin
        rd_seen <= rd_go;
        if (sys_reset_out) rst_seen <= 1'b1;
        if (rd_seen) begin
            rx = rq.pop_front();
            `CHK(reg_rd_data_out, rx)
        end
        if (armed && vec_load_out && !sys_reset_out) begin
            v = vq.size() ? vq.pop_front() : 'x;
            `CHK(vec_addr_out, v)
        end
    end
    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(negedge clk_sys_in) reg_wr_in = '{1'b1, a, d};
        @(negedge clk_sys_in) reg_wr_in.wr = 1'b0;
    endtask
    task automatic rd(logic [5:0] a, logic [7:0] e);
        @(negedge clk_sys_in) reg_rd_addr_in = a;
        rd_go = 1'b1;
        rq.push_back(e);
        @(negedge clk_sys_in) rd_go = 1'b0;
    endtask
    task automatic ins(logic [5:0] i);
        @(negedge clk_sys_in) instr_in = irwc_instr_t'(i);
        @(negedge clk_sys_in) instr_in = '0;
    endtask
    task automatic tk(bit w, int n);
        repeat (n) begin
            @(negedge clk_sys_in) {wd_clk_in, timer_clk_in} = {w, !w};
            @(negedge clk_sys_in) {wd_clk_in, timer_clk_in} = 2'b00;
        end
    endtask
    task automatic fall(int s);
        @(negedge clk_sys_in);
        if (s == 0) counter_one_flag_ovf_n_in = 1'b0;
        else if (s == 1) counter_two_flag_ovf_n_in = 1'b0;
        else if (s == 2) adc_done_n_in = 1'b0;
        else port7_in[s-3] = 1'b0;
        @(negedge clk_sys_in);
        {counter_one_flag_ovf_n_in, counter_two_flag_ovf_n_in, adc_done_n_in} = 3'b111;
        port7_in = 8'hFF;
    endtask
    function automatic logic [7:0] fb(int s);
        return s < 3 ? (s == 2 ? 8'h20 : 8'h02 << s) : (s < 7 ? 8'h08 : 8'h10);
    endfunction
    initial begin
        {clk_en_in, rst_n_in, por_in, volt_det_rst_in} = 4'h8;
        {volt_det_sel_in, timer_clk_in, wd_clk_in, rst_seen} = 4'h0;
        {counter_one_flag_ovf_n_in, counter_two_flag_ovf_n_in, adc_done_n_in} = 3'b111;
        {port7_in, reg_wr_in, reg_rd_addr_in, instr_in} = {8'hFF, 27'h0};
        r = 8'($urandom(32'ha7ba));
        tick(12);
        `CHK({vec_load_out, sys_reset_out, vec_addr_out}, {2'b11, IRWC_VEC_RESET})
        rst_n_in = 1'b1;
        tick(2);
        armed = 1'b1;
        foreach (RA[i]) rd(RA[i], RV[i]);
        wr(IRWC_ADDR_CONFIG, 8'h00);
        repeat (4) begin
            r = 8'($urandom);
            wr(IRWC_ADDR_MASK, r);
            rd(IRWC_ADDR_MASK, r & 8'h3F);
        end
        wr(IRWC_ADDR_MASK, 8'h3F);
        for (int s = 0; s < 11; s++) begin
            fall(s);
            rd(IRWC_ADDR_FLAG, fb(s));
            `CHK(irq_req_out, 1'b0)
            wr(IRWC_ADDR_FLAG, 8'h00);
        end
        wr(IRWC_ADDR_MASK, 8'h00);
        fall(3);
        tick(1);
        port7_in = 8'($urandom);
        tick(2);
        `CHK(port7_data_out, port7_in)
        port7_in = 8'hFF;
        rd(IRWC_ADDR_FLAG, 8'h00);
        wr(IRWC_ADDR_MASK, 8'h02);
        fall(0);
        vq.push_back(IRWC_VEC_HW);
        ins(6'h08);
        tick(2);
        `CHK(pc[12:3], 10'h001)
        rd(IRWC_ADDR_FLAG, 8'h02);
        wr(IRWC_ADDR_FLAG, 8'h00);
        ins(6'h02);
        ins(6'h04);
        fall(0);
        `CHK(irq_req_out, 1'b0)
        vq.push_back(IRWC_VEC_HW);
        ins(6'h08);
        tick(1);
        `CHK(irq_req_out, 1'b0)
        wr(IRWC_ADDR_FLAG, 8'h00);
        vq.push_back(IRWC_VEC_SOFT);
        ins(6'h01);
        tick(2);
        wr(IRWC_ADDR_TIMER, 8'h5A);
        rd(IRWC_ADDR_TIMER, 8'h00);
        tk(0, 1);
        wr(IRWC_ADDR_TIMER, 8'h00);
        tk(0, 3);
        rd(IRWC_ADDR_TIMER, 8'h01);
        wr(IRWC_ADDR_MASK, 8'h01);
        foreach (MD[i]) begin
            wr(IRWC_ADDR_MODE, MD[i]);
            ins(6'h08);
            wr(IRWC_ADDR_TIMER, 8'h00);
            tk(0, 1);
            if (MD[i][7]) ins(6'h10);
            tk(0, 1);
            tick(1);
            `CHK(cpu_halt_out, MD[i][7])
            `CHK(timer_out, 8'h01)
            vq.push_back(IRWC_VEC_HW);
            tk(0, 510);
            tick(2);
            `CHK(cpu_halt_out, 1'b0)
            rd(IRWC_ADDR_FLAG, 8'h01);
            wr(IRWC_ADDR_FLAG, 8'h00);
        end
        // Resets below would show a vector at 0, so stop watching
        armed = 1'b0;
        wr(IRWC_ADDR_STATUS, 8'hE5);
        wr(IRWC_ADDR_CONFIG, 8'h08);
        wr(IRWC_ADDR_MODE, 8'h20);
        ins(6'h10);
        rst_seen = 1'b0;
        tk(1, 300);
        `CHK(rst_seen, 1'b1)
        rd(IRWC_ADDR_CONFIG, 8'hFF);
        rd(IRWC_ADDR_STATUS, 8'hE5);
        rst_seen = 1'b0;
        tk(1, 300);
        `CHK(rst_seen, 1'b0)
        wr(IRWC_ADDR_CONFIG, 8'h08);
        wr(IRWC_ADDR_MODE, 8'h60);
        tk(1, 200);
        ins(6'h20);
        tk(1, 200);
        `CHK(rst_seen, 1'b0)
        tk(1, 100);
        `CHK(rst_seen, 1'b1)
        foreach (RT[i]) begin
            rst_seen = 1'b0;
            {volt_det_sel_in, por_in, volt_det_rst_in} = RT[i][3:1];
            tick(2);
            {por_in, volt_det_rst_in} = 2'b00;
            tick(2);
            `CHK(rst_seen, RT[i][0])
        end
        rd(IRWC_ADDR_STATUS, 8'h00);
        tick(1);
        `CHK(rq.size() + vq.size(), 0)
        stop_test();
    end
endmodule // tb_top
